/* File: hw/cgs_err_cnt.sv */
// Purpose: saturating error counter with overflow latch
// Assumes: increment and decrement arrive as same-clock pulses
// Notes: overflow stays until clear; counter holds at its top while latched
`timescale 1ns/100ps
`default_nettype none
module cgs_err_cnt #(
   parameter int unsigned W = 8,
   parameter logic USE_LOAD = 1'b0,
   parameter logic [7:0] LOAD_VAL = 8'h00
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [7:0] inc_i,
   input wire logic dec_i,
   input wire logic clr_i,
   output logic [W-1:0] cnt_o,
   output logic ovf_o
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic ovf_ff;
   logic nxt_ovf;
   logic [W:0] sum;
   localparam logic [7:0] CGS_PASSIVE_LIM_W = cgs_pkg::CGS_PASSIVE_LIM;

   always_comb begin
      sum = {1'b0, cnt_ff} + (W+1)'(inc_i);
      nxt_cnt = cnt_ff;
      nxt_ovf = ovf_ff;
      if (clr_i) begin
         nxt_cnt = '0;
         nxt_ovf = 1'b0;
      end else if (inc_i != 8'h00) begin
         // past the top: hold at maximum and flag it
         if (sum[W]) begin
            nxt_cnt = '1;
            nxt_ovf = 1'b1;
         end else begin
            nxt_cnt = sum[W-1:0];
         end
      end else if (dec_i && !ovf_ff) begin
         if (USE_LOAD && (cnt_ff > W'(CGS_PASSIVE_LIM_W))) begin
            nxt_cnt = W'(LOAD_VAL);
         end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         cnt_ff <= W'(cgs_pkg::CGS_CNT_RST);
         ovf_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         ovf_ff <= nxt_ovf;
      end
   end

   assign cnt_o = cnt_ff;
   assign ovf_o = ovf_ff;
endmodule
`default_nettype wire

/* File: hw/cgs_pkg.sv */
// Purpose: shared constants and carriers for the CAN general status/error block
// Assumes: 8-bit special-function register space, single system clock
// Notes: bit positions are register bit numbers
package cgs_pkg;

   // register addresses in the SFR space
   localparam logic [7:0] CGS_GIT_ADDR = 8'h9b;
   localparam logic [7:0] CGS_TEC_ADDR = 8'h9c;
   localparam logic [7:0] CGS_REC_ADDR = 8'h9d;
   localparam logic [7:0] CGS_GSTA_ADDR = 8'haa;

   // reset values
   localparam logic [7:0] CGS_GIT_RST = 8'h00;
   localparam logic [7:0] CGS_GSTA_RST = 8'h00;
   localparam logic [7:0] CGS_CNT_RST = 8'h00;

   // general status bit positions
   localparam int unsigned CGS_GSTA_OVL = 6;
   localparam int unsigned CGS_GSTA_TX = 4;
   localparam int unsigned CGS_GSTA_RX = 3;
   localparam int unsigned CGS_GSTA_EN = 2;
   localparam int unsigned CGS_GSTA_BUS_OFF_STATE = 1;
   localparam int unsigned CGS_GSTA_PASV = 0;

   // general interrupt bit positions
   localparam int unsigned CGS_GIT_SUM = 7;
   localparam int unsigned CGS_GIT_TOVF = 5;
   localparam int unsigned CGS_GIT_BOVR = 4;
   localparam int unsigned CGS_GIT_STUFF = 3;
   localparam int unsigned CGS_GIT_CRC = 2;
   localparam int unsigned CGS_GIT_FORM = 1;
   localparam int unsigned CGS_GIT_ACK = 0;

   // controller start-up delay, in clock cycles
   localparam logic [1:0] CGS_ENA_START_CYC = 2'h2;
   // equal bits allowed before a stuff violation
   localparam logic [2:0] CGS_STUFF_RUN_MAX = 3'h5;
   // crc-15 generator
   localparam logic [14:0] CGS_CRC_POLY = 15'h4599;
   localparam logic [14:0] CGS_CRC_RST = 15'h0000;
   localparam logic [15:0] CGS_TIMER_MAX = 16'hffff;
   localparam logic [15:0] CGS_TIMER_MIN = 16'h0000;

   // fault confinement figures
   localparam logic [7:0] CGS_PASSIVE_LIM = 8'h7f;
   localparam logic [7:0] CGS_TX_ERR_INC = 8'h08;
   localparam logic [7:0] CGS_RX_ERR_INC = 8'h01;
   localparam logic [7:0] CGS_RX_PRIM_INC = 8'h08;
   localparam logic [7:0] CGS_REC_PASSIVE_LOAD = 8'h77;

   typedef enum logic [1:0] {
      CGS_OFF = 2'b00,
      CGS_START = 2'b01,
      CGS_RUN = 2'b10,
      CGS_STOP = 2'b11
   } cgs_ena_state_t;

   // sampled bit stream from the protocol engine, one strobe per bit
   typedef struct packed {
      logic bit_stb;
      logic bit_val;
      logic sof;
      logic stuff_chk;
      logic crc_zone;
      logic crc_field;
      logic crc_end;
      logic form_chk;
      logic ack_slot;
      logic tx_role;
   } cgs_bits_t;

   // activity levels from the protocol engine
   typedef struct packed {
      logic tx_frame;
      logic tx_ack;
      logic ifs;
      logic tx_pending;
      logic rx_frame;
      logic ovl_tx;
   } cgs_act_t;

   // fault confinement events, one-cycle pulses
   typedef struct packed {
      logic tx_err;
      logic tx_ok;
      logic rx_err;
      logic rx_err_prim;
      logic rx_ok;
      logic bo_recover;
   } cgs_cnt_evt_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cgs_sfr_req_t;

endpackage

/* File: hw/cgs_status_regs.sv */
// Purpose: CAN general status, general interrupt and error counter registers
// Assumes: protocol engine signals are on clk_sys_i; SFR read data one cycle late
// Notes: writing 0 to a flag clears it, writing 1 leaves it; hardware set wins
// Functional notes
// - overload bit high while our own overload frame is sent; no interrupt
// - transmitter bit high for frames, ack bit, overload frame, or pending frame in interframe
// - receiver bit high while a bus frame is acquired or monitored
// - enabled bit shows real controller state, lagging the enable command
// - summary bit is the OR of all CAN interrupt requests
// - timer overflow flag sets when CAN timer wraps from ffff to 0000
// - timer overflow interrupts only if enabled; software clears flag to withdraw
// - buffer overrun flag sets when reception buffer fills; software clears it
// - stuff error flag sets on six equal consecutive bits; sticky until cleared
// - crc over sof to data compared with received crc; mismatch sets flag
// - form error on bad crc delimiter, ack delimiter or end of frame
// - ack error when transmitting and ack slot stays recessive
// - transmit error counter read-only, reset zero
// - receive error counter read-only, reset zero
// - enable starts after two clocks; disable finishes frame, then freezes recessive
`timescale 1ns/100ps
`default_nettype none
module cgs_status_regs (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire cgs_pkg::cgs_sfr_req_t sfr_req_i,
   input wire logic controller_enable_bit_i,
   input wire logic timer_overflow_irq_enable_i,
   input wire logic general_error_irq_enable_i,
   input wire logic buffer_irq_enable_i,
   input wire logic other_irq_i,
   input wire cgs_pkg::cgs_bits_t pe_bits_i,
   input wire cgs_pkg::cgs_act_t pe_act_i,
   input wire cgs_pkg::cgs_cnt_evt_t pe_cnt_i,
   input wire logic [15:0] can_timer_i,
   input wire logic rx_buffer_full_i,
   input wire logic pe_txd_i,
   output logic [7:0] sfr_rdata_o,
   output logic can_irq_o,
   output logic controller_run_o,
   output logic can_txd_o
);
   function automatic logic [14:0] crc_step(input logic [14:0] crc, input logic b);
      logic [14:0] sh;
      sh = {crc[13:0], 1'b0};
      if (b ^ crc[14]) begin
         sh = sh ^ cgs_pkg::CGS_CRC_POLY;
      end
      return sh;
   endfunction

   // ---------------- enable sequencing ----------------
   cgs_pkg::cgs_ena_state_t ena_ff;
   cgs_pkg::cgs_ena_state_t nxt_ena;
   logic [1:0] start_cnt_ff;
   logic [1:0] nxt_start_cnt;
   logic run_ff;
   logic nxt_run;
   logic txd_ff;
   logic nxt_txd;
   logic busy_frame;

   assign busy_frame = pe_act_i.tx_frame | pe_act_i.rx_frame | pe_act_i.tx_ack |
                       pe_act_i.ovl_tx;

   always_comb begin
      nxt_ena = ena_ff;
      nxt_start_cnt = start_cnt_ff;
      case (ena_ff)
         cgs_pkg::CGS_OFF: begin
            nxt_start_cnt = 2'h0;
            if (controller_enable_bit_i) begin
               nxt_ena = cgs_pkg::CGS_START;
            end
         end
         cgs_pkg::CGS_START: begin
            nxt_start_cnt = start_cnt_ff + 2'h1;
            if (!controller_enable_bit_i) begin
               nxt_ena = cgs_pkg::CGS_OFF;
            end else if (start_cnt_ff == cgs_pkg::CGS_ENA_START_CYC - 2'h1) begin
               nxt_ena = cgs_pkg::CGS_RUN;
            end
         end
         cgs_pkg::CGS_RUN: begin
            if (!controller_enable_bit_i) begin
               nxt_ena = cgs_pkg::CGS_STOP;
            end
         end
         cgs_pkg::CGS_STOP: begin
            if (controller_enable_bit_i) begin
               nxt_ena = cgs_pkg::CGS_RUN;
            end else if (!busy_frame) begin
               nxt_ena = cgs_pkg::CGS_OFF;
            end
         end
         default: begin
            nxt_ena = cgs_pkg::CGS_OFF;
         end
      endcase
      nxt_run = (nxt_ena == cgs_pkg::CGS_RUN) || (nxt_ena == cgs_pkg::CGS_STOP);
      nxt_txd = nxt_run ? pe_txd_i : 1'b1;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         ena_ff <= cgs_pkg::CGS_OFF;
         start_cnt_ff <= 2'h0;
         run_ff <= 1'b0;
         txd_ff <= 1'b1;
      end else begin
         ena_ff <= nxt_ena;
         start_cnt_ff <= nxt_start_cnt;
         run_ff <= nxt_run;
         txd_ff <= nxt_txd;
      end
   end

   // ---------------- error detection on the bit stream ----------------
   logic [2:0] run_len_ff;
   logic [2:0] nxt_run_len;
   logic last_bit_ff;
   logic nxt_last_bit;
   logic [14:0] crc_calc_ff;
   logic [14:0] nxt_crc_calc;
   logic [14:0] crc_rx_ff;
   logic [14:0] nxt_crc_rx;
   logic ev_stuff;
   logic ev_crc;
   logic ev_form;
   logic ev_ack;

   always_comb begin
      nxt_run_len = run_len_ff;
      nxt_last_bit = last_bit_ff;
      nxt_crc_calc = crc_calc_ff;
      nxt_crc_rx = crc_rx_ff;
      ev_stuff = 1'b0;
      ev_crc = 1'b0;
      ev_form = 1'b0;
      ev_ack = 1'b0;
      if (pe_bits_i.bit_stb && run_ff) begin
         if (!pe_bits_i.stuff_chk) begin
            nxt_run_len = 3'h0;
         end else if (run_len_ff != 3'h0 && pe_bits_i.bit_val == last_bit_ff) begin
            if (run_len_ff == cgs_pkg::CGS_STUFF_RUN_MAX) begin
               ev_stuff = 1'b1;
               nxt_run_len = 3'h0;
            end else begin
               nxt_run_len = run_len_ff + 3'h1;
            end
         end else begin
            nxt_run_len = 3'h1;
         end
         nxt_last_bit = pe_bits_i.bit_val;
         if (pe_bits_i.sof) begin
            nxt_crc_calc = crc_step(cgs_pkg::CGS_CRC_RST, pe_bits_i.bit_val);
            nxt_crc_rx = cgs_pkg::CGS_CRC_RST;
         end else if (pe_bits_i.crc_zone) begin
            nxt_crc_calc = crc_step(crc_calc_ff, pe_bits_i.bit_val);
         end else if (pe_bits_i.crc_field) begin
            nxt_crc_rx = {crc_rx_ff[13:0], pe_bits_i.bit_val};
         end
         ev_form = pe_bits_i.form_chk && !pe_bits_i.bit_val;
         ev_ack = pe_bits_i.ack_slot && pe_bits_i.tx_role && pe_bits_i.bit_val;
      end
      // compare at end of crc field
      if (pe_bits_i.crc_end && run_ff) begin
         ev_crc = (crc_calc_ff != crc_rx_ff);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         run_len_ff <= 3'h0;
         last_bit_ff <= 1'b1;
         crc_calc_ff <= cgs_pkg::CGS_CRC_RST;
         crc_rx_ff <= cgs_pkg::CGS_CRC_RST;
      end else begin
         run_len_ff <= nxt_run_len;
         last_bit_ff <= nxt_last_bit;
         crc_calc_ff <= nxt_crc_calc;
         crc_rx_ff <= nxt_crc_rx;
      end
   end

   // ---------------- sticky flags and interrupt ----------------
   logic [5:0] flags_ff;
   logic [5:0] nxt_flags;
   logic [5:0] set_vec;
   logic [5:0] clr_vec;
   logic [15:0] timer_prev_ff;
   logic buf_full_prev_ff;
   logic irq_ff;
   logic nxt_irq;
   logic git_wr;
   assign git_wr = sfr_req_i.wr && (sfr_req_i.addr == cgs_pkg::CGS_GIT_ADDR);
   always_comb begin
      set_vec = 6'h00;
      set_vec[cgs_pkg::CGS_GIT_TOVF] = (timer_prev_ff == cgs_pkg::CGS_TIMER_MAX) &&
                                        (can_timer_i == cgs_pkg::CGS_TIMER_MIN);
      set_vec[cgs_pkg::CGS_GIT_BOVR] = rx_buffer_full_i && !buf_full_prev_ff;
      set_vec[cgs_pkg::CGS_GIT_STUFF] = ev_stuff;
      set_vec[cgs_pkg::CGS_GIT_CRC] = ev_crc;
      set_vec[cgs_pkg::CGS_GIT_FORM] = ev_form;
      set_vec[cgs_pkg::CGS_GIT_ACK] = ev_ack;
      clr_vec = git_wr ? ~sfr_req_i.wdata[5:0] : 6'h00;
      // set wins over a clear in the same cycle
      nxt_flags = (flags_ff & ~clr_vec) | set_vec;
      nxt_irq = other_irq_i;
      if (flags_ff[cgs_pkg::CGS_GIT_TOVF] && timer_overflow_irq_enable_i) begin
         nxt_irq = 1'b1;
      end
      if (flags_ff[cgs_pkg::CGS_GIT_BOVR] && buffer_irq_enable_i) begin
         nxt_irq = 1'b1;
      end
      if ((|flags_ff[3:0]) && general_error_irq_enable_i) begin
         nxt_irq = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         flags_ff <= cgs_pkg::CGS_GIT_RST[5:0];
         timer_prev_ff <= cgs_pkg::CGS_TIMER_MIN;
         buf_full_prev_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         flags_ff <= nxt_flags;
         timer_prev_ff <= can_timer_i;
         buf_full_prev_ff <= rx_buffer_full_i;
         irq_ff <= nxt_irq;
      end
   end

   // ---------------- fault confinement ----------------
   logic [7:0] tec;
   logic [7:0] rec;
   logic tec_ovf;
   logic [7:0] tec_inc;
   logic [7:0] rec_inc;
   assign tec_inc = pe_cnt_i.tx_err ? cgs_pkg::CGS_TX_ERR_INC : 8'h00;
   assign rec_inc = pe_cnt_i.rx_err_prim ? cgs_pkg::CGS_RX_PRIM_INC :
                    (pe_cnt_i.rx_err ? cgs_pkg::CGS_RX_ERR_INC : 8'h00);
   cgs_err_cnt u_tec (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .inc_i(tec_inc),
      .dec_i(pe_cnt_i.tx_ok),
      .clr_i(pe_cnt_i.bo_recover),
      .cnt_o(tec),
      .ovf_o(tec_ovf)
   );

   cgs_err_cnt #(
      .W(8),
      .USE_LOAD(1'b1),
      .LOAD_VAL(cgs_pkg::CGS_REC_PASSIVE_LOAD)
   ) u_rec (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .inc_i(rec_inc),
      .dec_i(pe_cnt_i.rx_ok),
      .clr_i(pe_cnt_i.bo_recover),
      .cnt_o(rec),
      .ovf_o()
   );

   // ---------------- status and read port ----------------
   logic [7:0] gsta_ff;
   logic [7:0] nxt_gsta;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   always_comb begin
      nxt_gsta = cgs_pkg::CGS_GSTA_RST;
      nxt_gsta[cgs_pkg::CGS_GSTA_OVL] = run_ff && pe_act_i.ovl_tx;
      // frame, ack, overload frame, or pending in interframe
      nxt_gsta[cgs_pkg::CGS_GSTA_TX] = run_ff && (pe_act_i.tx_frame || pe_act_i.tx_ack ||
                                        pe_act_i.ovl_tx ||
                                        (pe_act_i.ifs && pe_act_i.tx_pending));
      nxt_gsta[cgs_pkg::CGS_GSTA_RX] = run_ff && pe_act_i.rx_frame;
      nxt_gsta[cgs_pkg::CGS_GSTA_EN] = run_ff;
      nxt_gsta[cgs_pkg::CGS_GSTA_BUS_OFF_STATE] = tec_ovf;
      nxt_gsta[cgs_pkg::CGS_GSTA_PASV] = !tec_ovf && ((tec > cgs_pkg::CGS_PASSIVE_LIM) ||
                                         (rec > cgs_pkg::CGS_PASSIVE_LIM));
   end
   always_comb begin
      nxt_rdata = 8'h00;
      if (sfr_req_i.rd) begin
         case (sfr_req_i.addr)
            cgs_pkg::CGS_GIT_ADDR: nxt_rdata = {irq_ff, 1'b0, flags_ff};
            cgs_pkg::CGS_TEC_ADDR: nxt_rdata = tec;
            cgs_pkg::CGS_REC_ADDR: nxt_rdata = rec;
            cgs_pkg::CGS_GSTA_ADDR: nxt_rdata = gsta_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         gsta_ff <= cgs_pkg::CGS_GSTA_RST;
         rdata_ff <= 8'h00;
      end else begin
         gsta_ff <= nxt_gsta;
         rdata_ff <= nxt_rdata;
      end
   end

   // reserved bits read zero; writes there are ignored
   assign sfr_rdata_o = rdata_ff;
   assign can_irq_o = irq_ff;
   assign controller_run_o = run_ff;
   assign can_txd_o = txd_ff;
endmodule
`default_nettype wire

/* File: sim/cgs_pe_model.sv */
// Purpose: protocol engine model streaming sampled bus bits
// Assumes: one strobe every second cycle, msb first
// Notes: qualifiers are zero between strobes, except crc_end in the gap after the last bit
`timescale 1ns/100ps
`default_nettype none
module cgs_pe_model (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic go_i,
   input wire cgs_pkg::cgs_bits_t qual_i,
   input wire logic [4:0] nb_i,
   input wire logic [15:0] dat_i,
   output var cgs_pkg::cgs_bits_t bits_o,
   output logic busy_o
);
   cgs_pkg::cgs_bits_t q;
   logic [15:0] sh;
   logic [4:0] left;
   logic gap;
   logic first;
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         busy_o <= 1'b0;
         bits_o <= '0;
         gap <= 1'b0;
      end else if (go_i && !busy_o) begin
         busy_o <= 1'b1;
         q <= qual_i;
         sh <= dat_i << (5'd16 - nb_i);
         left <= nb_i;
         gap <= 1'b0;
         first <= 1'b1;
      end else if (busy_o && !gap) begin
         // strobe with its qualifiers; sof only on the first bit
         bits_o <= {1'b1, sh[15], q.sof & first, q[6:4], 1'b0, q[2:0]};
         sh <= sh << 1;
         left <= left - 5'd1;
         first <= 1'b0;
         gap <= 1'b1;
      end else begin
         // no stale bit between strobes
         bits_o <= {1'b0, ~bits_o.bit_val, 4'h0, busy_o & q.crc_end & (left == 5'd0), 3'h0};
         busy_o <= busy_o & (left != 5'd0);
         gap <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: sim/cgs_status_regs_checker.sv */
// Purpose: port assertions for the CAN general status block
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every cgs_status_regs
`timescale 1ns/100ps
`default_nettype none
module cgs_status_regs_checker (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire cgs_pkg::cgs_sfr_req_t sfr_req_i,
   input wire logic controller_enable_bit_i,
   input wire logic timer_overflow_irq_enable_i,
   input wire logic general_error_irq_enable_i,
   input wire logic buffer_irq_enable_i,
   input wire logic other_irq_i,
   input wire cgs_pkg::cgs_bits_t pe_bits_i,
   input wire cgs_pkg::cgs_act_t pe_act_i,
   input wire cgs_pkg::cgs_cnt_evt_t pe_cnt_i,
   input wire logic [15:0] can_timer_i,
   input wire logic rx_buffer_full_i,
   input wire logic pe_txd_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic can_irq_o,
   input wire logic controller_run_o,
   input wire logic can_txd_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);
   a_reset_clears_outs: assert property (
      @(posedge clk_sys_i) disable iff (1'b0) !nrst_i |=>
      sfr_rdata_o == 8'h00 && !can_irq_o && !controller_run_o && can_txd_o)
      else $error("outputs not cleared by reset");
   a_summary_mirror: assert property (
      sfr_req_i.rd && sfr_req_i.addr == cgs_pkg::CGS_GIT_ADDR ##1 $stable(can_irq_o)
      |-> sfr_rdata_o[cgs_pkg::CGS_GIT_SUM] == can_irq_o)
      else $error("summary bit differs from interrupt line");
   a_other_irq_seen: assert property (
      other_irq_i |=> can_irq_o)
      else $error("folded interrupt request not raised");
   a_masked_quiet: assert property (
      !timer_overflow_irq_enable_i && !general_error_irq_enable_i && !buffer_irq_enable_i
      && !other_irq_i |=> !can_irq_o)
      else $error("interrupt raised with all sources masked");
   a_timer_wrap_irq: assert property (
      $past(can_timer_i) == cgs_pkg::CGS_TIMER_MAX && can_timer_i == cgs_pkg::CGS_TIMER_MIN
      && timer_overflow_irq_enable_i ##1 timer_overflow_irq_enable_i && !sfr_req_i.wr
      |=> can_irq_o)
      else $error("timer wrap did not interrupt");
   a_run_start_lag: assert property (
      $rose(controller_enable_bit_i) && !controller_run_o
      |-> !controller_run_o ##1 !controller_run_o ##[1:3] controller_run_o)
      else $error("controller start delay wrong");
   a_enabled_flag: assert property (
      sfr_req_i.rd && sfr_req_i.addr == cgs_pkg::CGS_GSTA_ADDR
      && $past(controller_run_o) == controller_run_o
      && $past(controller_run_o, 2) == controller_run_o
      |=> sfr_rdata_o[cgs_pkg::CGS_GSTA_EN] == $past(controller_run_o))
      else $error("enabled flag differs from controller state");
   a_frozen_recessive: assert property (
      !controller_run_o && !$past(controller_run_o) |-> can_txd_o)
      else $error("bus not recessive while frozen");
endmodule
bind cgs_status_regs cgs_status_regs_checker cgs_status_regs_checker_i (
   .clk_sys_i, .nrst_i, .sfr_req_i, .controller_enable_bit_i, .timer_overflow_irq_enable_i,
   .general_error_irq_enable_i, .buffer_irq_enable_i, .other_irq_i, .pe_bits_i, .pe_act_i,
   .pe_cnt_i, .can_timer_i, .rx_buffer_full_i, .pe_txd_i, .sfr_rdata_o, .can_irq_o,
   .controller_run_o, .can_txd_o);
`default_nettype wire

/* File: sim/test_can_global_status_error_flags.sv */
// Purpose: self-checking bench for the CAN general status block
// Assumes: reads answer one cycle after the strobe edge
// Notes: expected read data queued by the driver, popped by the monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module test_can_global_status_error_flags;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   cgs_pkg::cgs_sfr_req_t req = '0;
   cgs_pkg::cgs_act_t act = '0;
   cgs_pkg::cgs_cnt_evt_t cnt = '0;
   cgs_pkg::cgs_bits_t qual = '0;
   cgs_pkg::cgs_bits_t bits;
   logic en = 0, tim_en = 0, err_en = 0, buf_en = 0, oth = 0, bfull = 0, txd_in = 0, go = 0;
   logic [15:0] timer = 16'h0000;
   logic [15:0] dat = '0;
   logic [15:0] d_v;
   logic [4:0] nb = '0;
   logic [7:0] rdata, e_v;
   logic busy, irq, run, txd;
   logic rd_d = 1'b0;
   logic [7:0] expq[$];
   logic [7:0] addrs[5] = '{8'h9b, 8'h9c, 8'h9d, 8'haa, 8'h9e};
   logic [5:0] acts[6] = '{6'h20, 6'h10, 6'h0c, 6'h08, 6'h02, 6'h01};
   logic [7:0] gsta[6] = '{8'h14, 8'h14, 8'h14, 8'h04, 8'h0c, 8'h54};
   int miscompares = 0;
   int total_checks = 0;
   int n;
   always #2.5 clk_sys_i = ~clk_sys_i;
   cgs_status_regs cgs_status_regs_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sfr_req_i(req),
      .controller_enable_bit_i(en), .timer_overflow_irq_enable_i(tim_en),
      .general_error_irq_enable_i(err_en), .buffer_irq_enable_i(buf_en), .other_irq_i(oth),
      .pe_bits_i(bits), .pe_act_i(act), .pe_cnt_i(cnt), .can_timer_i(timer),
      .rx_buffer_full_i(bfull), .pe_txd_i(txd_in), .sfr_rdata_o(rdata), .can_irq_o(irq),
      .controller_run_o(run), .can_txd_o(txd));
   cgs_pe_model cgs_pe_model_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .go_i(go),
      .qual_i(qual), .nb_i(nb), .dat_i(dat), .bits_o(bits), .busy_o(busy));
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      req.rd <= 1'b1;
      req.addr <= a;
      expq.push_back(e);
      tick(1);
      req.rd <= 1'b0;
      tick(1);
   endtask
   // reserved bits always written as zero
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      tick(1);
      req.wr <= 1'b0;
      tick(1);
   endtask
   task automatic pulse(input logic [5:0] e, input int k);
      repeat (k) begin
         cnt <= cgs_pkg::cgs_cnt_evt_t'(e);
         tick(1);
         cnt <= '0;
         tick(1);
      end
   endtask
   task automatic send(input logic [9:0] q, input logic [4:0] k, input logic [15:0] d);
      int w;
      w = 0;
      qual <= cgs_pkg::cgs_bits_t'(q);
      nb <= k;
      dat <= d;
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(1);
      while (busy && w < 100) begin
         tick(1);
         w++;
      end
      tick(2);
   endtask
   function automatic logic [14:0] crc15(input logic [15:0] d);
      logic [14:0] c;
      logic b;
      c = cgs_pkg::CGS_CRC_RST;
      for (int i = 15; i >= 0; i--) begin
         b = d[i] ^ c[14];
         c = {c[13:0], 1'b0};
         if (b) c = c ^ cgs_pkg::CGS_CRC_POLY;
      end
      return c;
   endfunction
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      rd_d <= req.rd;
      if (rd_d) begin
         e_v = expq.pop_front();
         `CHK(rdata, e_v)
      end
   end
   initial begin
      tick(5000);
      miscompares++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h5b831037));
      tick(2);
      nrst_i <= 1'b1;
      tick(1);
      foreach (addrs[i]) rd(addrs[i], 8'h00);
      en <= 1'b1;
      tick(8);
      rd(8'haa, 8'h04);
      for (int i = 0; i < 6; i++) begin
         act <= cgs_pkg::cgs_act_t'(acts[i]);
         tick(3);
         `CHK(irq, 1'b0)
         rd(8'haa, gsta[i]);
      end
      act <= '0;
      timer <= 16'hffff;
      tick(1);
      timer <= 16'h0000;
      tick(3);
      `CHK(irq, 1'b0)
      rd(8'h9b, 8'h20);
      tim_en <= 1'b1;
      tick(3);
      `CHK(irq, 1'b1)
      rd(8'h9b, 8'ha0);
      wr(8'h9b, 8'h1f);
      tick(2);
      `CHK(irq, 1'b0)
      rd(8'h9b, 8'h00);
      timer <= 16'hffff;
      tick(1);
      timer <= 16'h0000;
      tick(3);
      `CHK(irq, 1'b1)
      wr(8'h9b, 8'h1f);
      buf_en <= 1'b1;
      bfull <= 1'b1;
      tick(3);
      `CHK(irq, 1'b1)
      rd(8'h9b, 8'h90);
      bfull <= 1'b0;
      wr(8'h9b, 8'h2f);
      rd(8'h9b, 8'h00);
      send(10'h040, 5'd7, 16'h0002);
      rd(8'h9b, 8'h00);
      send(10'h040, 5'd6, 16'h003f);
      `CHK(irq, 1'b0)
      rd(8'h9b, 8'h08);
      err_en <= 1'b1;
      tick(3);
      rd(8'h9b, 8'h88);
      wr(8'h9b, 8'h00);
      send(10'h004, 5'd1, 16'h0000);
      rd(8'h9b, 8'h82);
      wr(8'h9b, 8'h00);
      send(10'h003, 5'd1, 16'h0001);
      rd(8'h9b, 8'h81);
      wr(8'h9b, 8'h00);
      d_v = 16'($urandom) & 16'h7fff;
      for (int f = 0; f < 2; f++) begin
         send(10'h0a0, 5'd16, d_v);
         send(10'h018, 5'd15, {1'b0, crc15(d_v) ^ 15'(f)});
         rd(8'h9b, (f == 1) ? 8'h84 : 8'h00);
         wr(8'h9b, 8'h00);
      end
      n = 1 + ($urandom % 15);
      pulse(6'h20, n);
      rd(8'h9c, 8'(n * 8));
      wr(8'h9c, 8'($urandom));
      rd(8'h9c, 8'(n * 8));
      pulse(6'h10, 1);
      rd(8'h9c, 8'(n * 8 - 1));
      pulse(6'h0c, 1);
      pulse(6'h08, 1);
      rd(8'h9d, 8'h09);
      pulse(6'h02, 1);
      rd(8'h9d, 8'h08);
      pulse(6'h04, 15);
      rd(8'haa, 8'h05);
      pulse(6'h02, 1);
      rd(8'h9d, 8'h77);
      pulse(6'h20, 17 - n);
      rd(8'haa, 8'h05);
      pulse(6'h20, 16);
      rd(8'h9c, 8'hff);
      rd(8'haa, 8'h06);
      pulse(6'h01, 1);
      rd(8'h9c, 8'h00);
      rd(8'haa, 8'h04);
      oth <= 1'b1;
      tick(3);
      rd(8'h9b, 8'h80);
      oth <= 1'b0;
      act <= cgs_pkg::cgs_act_t'(6'h02);
      en <= 1'b0;
      tick(8);
      `CHK(run, 1'b1)
      `CHK(txd, 1'b0)
      act <= '0;
      tick(8);
      `CHK(run, 1'b0)
      `CHK(txd, 1'b1)
      rd(8'haa, 8'h00);
      tick(3);
      end_of_test();
   end
endmodule
`default_nettype wire
